//--- rtl/bmxcfg_pkg.sv
/*
 bus matrix configuration package: register offsets, field positions, reset values,
 arbitration modes and initiator indices.
 assumes a 32-bit word-addressed register port with byte addresses.
*/
package bmxcfg_pkg;
   localparam int          ADDR_W            = 8;
   localparam logic [7:0]  OFS_CFG           = 8'h00;
   localparam logic [7:0]  OFS_KPB           = 8'h10;
   localparam logic [7:0]  OFS_RAMSZ         = 8'h40;
   localparam logic [7:0]  OFS_IRQ_STAT      = 8'h80;
   localparam logic [7:0]  OFS_IRQ_MASK      = 8'h84;
   localparam logic [3:0]  ALIAS_CLR         = 4'h4;
   localparam logic [3:0]  ALIAS_SET         = 4'h8;
   localparam logic [3:0]  ALIAS_INV         = 4'hC;
   localparam int          BIT_ERR_SHARED    = 20;
   localparam int          BIT_ERR_DEBUG     = 19;
   localparam int          BIT_ERR_DMA       = 18;
   localparam int          BIT_ERR_DATA      = 17;
   localparam int          BIT_ERR_FETCH     = 16;
   localparam int          BIT_WAIT          = 6;
   localparam logic [31:0] CFG_WMASK         = 32'h001F_0047;
   localparam logic [31:0] CFG_RESET         = 32'h001F_0041;
   localparam logic [31:0] KPB_WMASK         = 32'h0000_FC00;
   localparam logic [31:0] KPB_RESET         = 32'h0000_0000;
   localparam logic [31:0] RAMSZ_DEFAULT     = 32'h0000_8000;
   localparam int          N_INIT            = 5;
   localparam logic [4:0]  IRQ_WMASK         = 5'h1F;
   localparam logic [4:0]  IRQ_RESET         = 5'h00;
   // initiator indices, matching the enable bit order from bit 16 upward
   localparam int          INI_FETCH         = 0;
   localparam int          INI_DATA          = 1;
   localparam int          INI_DMA           = 2;
   localparam int          INI_DEBUG         = 3;
   localparam int          INI_SHARED        = 4;

   typedef enum logic [2:0] {
      BMXCFG_ARB_MODE0 = 3'b000,
      BMXCFG_ARB_MODE1 = 3'b001,
      BMXCFG_ARB_MODE2 = 3'b010
   } bmxcfg_arb_e;
endpackage

//--- rtl/bmxcfg_alias_reg.sv
/*
 32-bit register with plain, clear, set and invert write ports.
 assumes strobes decoded by the parent; unwritable bits held at their reset value.
*/
`timescale 1ns/10ps
module bmxcfg_alias_reg
   import bmxcfg_pkg::*;
#(
   parameter logic [31:0] WMASK = 32'h0,
   parameter logic [31:0] RESET = 32'h0
) (
   input  wire logic        i_clk,    // system clock
   input  wire logic        i_rst,    // synchronous reset
   input  wire logic        i_wr,     // plain write
   input  wire logic        i_clr,    // clear-alias write
   input  wire logic        i_set,    // set-alias write
   input  wire logic        i_inv,    // invert-alias write
   input  wire logic [31:0] i_data,   // write data
   output logic      [31:0] o_q       // register value
);
   logic [31:0] q_reg;
   logic [31:0] q_next;
   wire  [31:0] m = i_data & WMASK;

   // unwritable bits always keep reset value, so reserved bits read as zero
   assign q_next = i_wr  ? ((q_reg & ~WMASK) | m) :
                   i_clr ? (q_reg & ~m) :
                   i_set ? (q_reg | m) :
                   i_inv ? (q_reg ^ m) : q_reg;

   always_ff @(posedge i_clk) begin
      if (i_rst) begin
         q_reg <= RESET;
      end else begin
         q_reg <= q_next;
      end
   end
   assign o_q = q_reg;
endmodule

//--- rtl/bmxcfg_err_gate.sv
/*
 per-initiator unmapped-access error gate: one cycle from request to error pulse.
 assumes unmapped decode and debug mode come from logic on the same clock.
*/
`timescale 1ns/10ps
module bmxcfg_err_gate
   import bmxcfg_pkg::*;
(
   input  wire logic              i_clk,      // system clock
   input  wire logic              i_rst,      // synchronous reset
   input  wire logic [N_INIT-1:0] i_unmapped, // unmapped access started, per initiator
   input  wire logic [N_INIT-1:0] i_enable,   // error enables
   input  wire logic              i_debug,    // cpu in debug mode
   output logic      [N_INIT-1:0] o_err       // error response pulses
);
   logic [N_INIT-1:0] err_reg;
   logic [N_INIT-1:0] qual;

   always_comb begin
      qual = i_enable;
      // cpu sources silenced in debug mode
      qual[INI_DATA]  = i_enable[INI_DATA]  & ~i_debug;
      qual[INI_FETCH] = i_enable[INI_FETCH] & ~i_debug;
   end

   always_ff @(posedge i_clk) begin
      if (i_rst) begin
         err_reg <= '0;
      end else begin
         err_reg <= i_unmapped & qual;
      end
   end
   assign o_err = err_reg;
endmodule

//--- rtl/bmxcfg_top.sv
/*
 bus matrix configuration block: configuration and kernel-base registers with aliases,
 error response gating per initiator, wait-state and arbitration outputs, error interrupt.
 assumes a single-cycle register port with read data one cycle after the read strobe,
 and unmapped-access decode supplied by the matrix on the same clock.
*/
// Decided for this implementation: the address map and the address-and-strobe port.
`timescale 1ns/10ps
module bmxcfg_top
   import bmxcfg_pkg::*;
(
   input  wire logic              i_clk,        // system clock 10 MHz
   input  wire logic              i_rst,        // synchronous reset, active high
   input  wire logic [ADDR_W-1:0] i_addr,       // register byte address
   input  wire logic [31:0]       i_wdata,      // write data
   input  wire logic              i_wr,         // write strobe
   input  wire logic              i_rd,         // read strobe
   output logic      [31:0]       o_rdata,      // read data, cycle after strobe
   input  wire logic [N_INIT-1:0] i_unmapped,   // unmapped access pulse per initiator
   input  wire logic              i_debug_mode, // cpu in debug mode
   output logic      [N_INIT-1:0] o_bus_err,    // error response per initiator
   output logic                   o_ram_wait,   // one wait state on cpu data ram
   output logic      [2:0]        o_arb_mode,   // arbitration mode select
   output logic      [15:0]       o_kern_base,  // kernel program base in data ram
   output logic                   o_irq         // error interrupt level
);
   ////////////////////////////////////////////////////////////////////////////////
   // address decode
   wire  [ADDR_W-1:0] base_addr = {i_addr[ADDR_W-1:4], 4'h0};
   wire  [3:0]        sub_addr  = i_addr[3:0];
   wire               hit_cfg   = (base_addr == OFS_CFG);
   wire               hit_kpb   = (base_addr == OFS_KPB);
   wire               hit_sz    = (i_addr == OFS_RAMSZ);
   wire               hit_stat  = (i_addr == OFS_IRQ_STAT);
   wire               hit_mask  = (i_addr == OFS_IRQ_MASK);
   wire               s_wr      = i_wr & (sub_addr == 4'h0);
   wire               s_clr     = i_wr & (sub_addr == ALIAS_CLR);
   wire               s_set     = i_wr & (sub_addr == ALIAS_SET);
   wire               s_inv     = i_wr & (sub_addr == ALIAS_INV);

   logic [31:0] cfg_q;
   logic [31:0] kpb_q;

   ////////////////////////////////////////////////////////////////////////////////
   // configuration register with aliases; reserved bits masked off
   bmxcfg_alias_reg #(
      .WMASK (CFG_WMASK),
      .RESET (CFG_RESET)
   ) u_cfg (
      .i_clk  (i_clk),
      .i_rst  (i_rst),
      .i_wr   (hit_cfg & s_wr),
      .i_clr  (hit_cfg & s_clr),
      .i_set  (hit_cfg & s_set),
      .i_inv  (hit_cfg & s_inv),
      .i_data (i_wdata),
      .o_q    (cfg_q)
   );

   // kernel base: only bits 15-10 writable, reset zero
   bmxcfg_alias_reg #(
      .WMASK (KPB_WMASK),
      .RESET (KPB_RESET)
   ) u_kpb (
      .i_clk  (i_clk),
      .i_rst  (i_rst),
      .i_wr   (hit_kpb & s_wr),
      .i_clr  (hit_kpb & s_clr),
      .i_set  (hit_kpb & s_set),
      .i_inv  (hit_kpb & s_inv),
      .i_data (i_wdata),
      .o_q    (kpb_q)
   );

   ////////////////////////////////////////////////////////////////////////////////
   // error response gating
   logic [N_INIT-1:0] err_w;
   wire  [N_INIT-1:0] err_en = cfg_q[BIT_ERR_SHARED:BIT_ERR_FETCH];

   bmxcfg_err_gate u_gate (
      .i_clk      (i_clk),
      .i_rst      (i_rst),
      .i_unmapped (i_unmapped),
      .i_enable   (err_en),
      .i_debug    (i_debug_mode),
      .o_err      (err_w)
   );

   ////////////////////////////////////////////////////////////////////////////////
   // interrupt status and mask
   logic [N_INIT-1:0] stat_reg;
   logic [N_INIT-1:0] stat_next;
   logic [N_INIT-1:0] mask_reg;
   logic [N_INIT-1:0] mask_next;
   wire               stat_w1c  = i_wr & hit_stat;
   wire               mask_wr   = i_wr & hit_mask;

   // a new error in the clear cycle survives the clear
   assign stat_next = (stat_reg & ~(stat_w1c ? i_wdata[N_INIT-1:0] : IRQ_RESET)) | err_w;
   assign mask_next = mask_wr ? (i_wdata[N_INIT-1:0] & IRQ_WMASK) : mask_reg;

   ////////////////////////////////////////////////////////////////////////////////
   // read mux
   logic [31:0] rd_next;
   assign rd_next = (hit_cfg & (sub_addr == 4'h0)) ? cfg_q :
                    (hit_kpb & (sub_addr == 4'h0)) ? kpb_q :
                    hit_sz   ? RAMSZ_DEFAULT :
                    hit_stat ? {27'h0, stat_reg} :
                    hit_mask ? {27'h0, mask_reg} : 32'h0;

   ////////////////////////////////////////////////////////////////////////////////
   // output registers
   logic [31:0]       rdata_reg;
   logic [N_INIT-1:0] bus_err_reg;
   logic              wait_reg;
   logic [2:0]        arb_reg;
   logic [15:0]       kern_reg;
   logic              irq_reg;

   always_ff @(posedge i_clk) begin
      if (i_rst) begin
         stat_reg <= IRQ_RESET;
         mask_reg <= IRQ_RESET;
      end else begin
         stat_reg <= stat_next;
         mask_reg <= mask_next;
      end
   end

   always_ff @(posedge i_clk) begin
      if (i_rst) begin
         rdata_reg <= 32'h0;
      end else begin
         rdata_reg <= i_rd ? rd_next : 32'h0;
      end
   end

   // outputs lag the registers by one cycle, except irq, which is built from the next status and mask and does not lag
   always_ff @(posedge i_clk) begin
      if (i_rst) begin
         bus_err_reg <= '0;
         wait_reg    <= CFG_RESET[BIT_WAIT];
         arb_reg     <= BMXCFG_ARB_MODE1;
         kern_reg    <= KPB_RESET[15:0];
         irq_reg     <= 1'b0;
      end else begin
         bus_err_reg <= err_w;
         wait_reg    <= cfg_q[BIT_WAIT];
         arb_reg     <= cfg_q[2:0];
         kern_reg    <= kpb_q[15:0];
         irq_reg     <= |(stat_next & mask_next);
      end
   end

   assign o_rdata     = rdata_reg;
   assign o_bus_err   = bus_err_reg;
   assign o_ram_wait  = wait_reg;
   assign o_arb_mode  = arb_reg;
   assign o_kern_base = kern_reg;
   assign o_irq       = irq_reg;
endmodule

//--- sim/bmxcfg_initiators.sv
/*
 initiator side model: turns requests into one-cycle unmapped accesses, counts error responses.
 assumes the bench raises requests for one cycle at a rising edge.
*/
`timescale 1ns/10ps
module bmxcfg_initiators (
   input  wire logic       i_clk,        // clock
   input  wire logic       i_rst,        // sync reset
   input  wire logic [4:0] i_req,        // accesses to start
   input  wire logic       i_dbg,        // enter debug mode
   input  wire logic [4:0] i_bus_err,    // error responses
   output logic      [4:0] o_unmapped,   // one cycle per access
   output logic            o_debug_mode, // cpu debug state
   output logic      [7:0] o_err_cnt     // responses received
);
   always_ff @(posedge i_clk) begin
      o_unmapped   <= i_req;
      o_debug_mode <= i_dbg;
      if (i_rst) begin
         o_err_cnt <= 8'h00;
      end else begin
         o_err_cnt <= o_err_cnt + 8'($countones(i_bus_err));
      end
   end
endmodule

//--- sim/bmxcfg_asserts.sv
/*
 checker for the configuration block, bound to its top module.
 assumes one clock and a synchronous active-high reset.
*/
`timescale 1ns/10ps
module bmxcfg_chk
   import bmxcfg_pkg::*;
(
   input wire logic        i_clk,        // clock
   input wire logic        i_rst,        // reset
   input wire logic [7:0]  i_addr,       // address
   input wire logic [31:0] i_wdata,      // write data
   input wire logic        i_wr,         // write
   input wire logic        i_rd,         // read
   input wire logic [31:0] o_rdata,      // read data
   input wire logic [4:0]  i_unmapped,   // accesses
   input wire logic        i_debug_mode, // debug
   input wire logic [4:0]  o_bus_err,    // errors
   input wire logic        o_ram_wait,   // wait state
   input wire logic [2:0]  o_arb_mode,   // arbitration
   input wire logic [15:0] o_kern_base   // kernel base
);
   default clocking @(posedge i_clk); endclocking
   default disable iff (i_rst);
   property p_err_src;
      o_bus_err != 5'h00 |-> (o_bus_err & ~$past(i_unmapped, 2)) == 5'h00;
   endproperty
   a_err_src: assert property (p_err_src) else $error("error without access");
   property p_dbg_data;
      o_bus_err[1] |-> !$past(i_debug_mode, 2);
   endproperty
   a_dbg_data: assert property (p_dbg_data) else $error("data error in debug");
   property p_dbg_fetch;
      o_bus_err[0] |-> !$past(i_debug_mode, 2);
   endproperty
   a_dbg_fetch: assert property (p_dbg_fetch) else $error("fetch error in debug");
   property p_cfg_rd;
      $past(i_rd) && $past(i_addr) == OFS_CFG |-> (o_rdata & ~CFG_WMASK) == 32'h0;
   endproperty
   a_cfg_rd: assert property (p_cfg_rd) else $error("config spare bits set");
   property p_kpb_rd;
      $past(i_rd) && $past(i_addr) == OFS_KPB |-> (o_rdata & ~KPB_WMASK) == 32'h0;
   endproperty
   a_kpb_rd: assert property (p_kpb_rd) else $error("base spare bits set");
   property p_cfg_wr;
      !$past(i_rst) && !$past(i_rst, 2) && $past(i_wr, 2) && $past(i_addr, 2) == OFS_CFG
         |-> o_ram_wait == $past(i_wdata[6], 2) && o_arb_mode == $past(i_wdata[2:0], 2);
   endproperty
   a_cfg_wr: assert property (p_cfg_wr) else $error("config outputs wrong");
   property p_kb_wr;
      !$past(i_rst) && !$past(i_rst, 2) && $past(i_wr, 2) && $past(i_addr, 2) == OFS_KPB
         |-> o_kern_base == ($past(i_wdata[15:0], 2) & 16'hFC00);
   endproperty
   a_kb_wr: assert property (p_kb_wr) else $error("kernel base wrong");
   property p_rst;
      $fell(i_rst) |-> o_kern_base == 16'h0 && o_arb_mode == 3'b001 && o_ram_wait;
   endproperty
   a_rst: assert property (p_rst) else $error("reset values wrong");
endmodule
bind bmxcfg_top bmxcfg_chk u_chk (.i_clk(i_clk), .i_rst(i_rst), .i_addr(i_addr),
   .i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata), .i_unmapped(i_unmapped),
   .i_debug_mode(i_debug_mode), .o_bus_err(o_bus_err), .o_ram_wait(o_ram_wait),
   .o_arb_mode(o_arb_mode), .o_kern_base(o_kern_base));

//--- sim/tb_bus_matrix_config_ram_partition.sv
/*
 bench for the configuration block: register tasks, alias, base and error scenarios.
 assumes the initiator model drives the unmapped-access inputs.
*/
`timescale 1ns/10ps
module tb_bus_matrix_config_ram_partition
   import bmxcfg_pkg::*;
;
   logic        i_clk = 1'b0, i_rst = 1'b1, i_wr = 1'b0, i_rd = 1'b0, dbg = 1'b0;
   logic [7:0]  i_addr = 8'h00, ecnt, base;
   logic [31:0] i_wdata = 32'h0, o_rdata;
   logic [4:0]  req = 5'h00, unm, o_bus_err;
   logic        dbm, o_ram_wait, o_irq;
   logic [2:0]  o_arb_mode;
   logic [15:0] o_kern_base;
   int          n_fail = 0, check_count = 0;
   always #50 i_clk = ~i_clk;
   bmxcfg_top dut (.i_clk(i_clk), .i_rst(i_rst), .i_addr(i_addr), .i_wdata(i_wdata),
      .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata), .i_unmapped(unm), .i_debug_mode(dbm),
      .o_bus_err(o_bus_err), .o_ram_wait(o_ram_wait), .o_arb_mode(o_arb_mode),
      .o_kern_base(o_kern_base), .o_irq(o_irq));
   bmxcfg_initiators u_init (.i_clk(i_clk), .i_rst(i_rst), .i_req(req), .i_dbg(dbg),
      .i_bus_err(o_bus_err), .o_unmapped(unm), .o_debug_mode(dbm), .o_err_cnt(ecnt));
   ////////////////////////////////////////
   task automatic chk(input string nm, input logic [31:0] got, input logic [31:0] exp);
      check_count++;
      if (got !== exp) begin
         n_fail++;
         $display("MISMATCH %s expected %h seen %h", nm, exp, got);
      end
   endtask
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      @(posedge i_clk);
      i_wr <= 1'b1;
      i_addr <= a;
      i_wdata <= d;
      @(posedge i_clk);
      i_wr <= 1'b0;
   endtask
   task automatic rd(input logic [7:0] a, input logic [31:0] e);
      @(posedge i_clk);
      i_rd <= 1'b1;
      i_addr <= a;
      @(posedge i_clk);
      i_rd <= 1'b0;
      #1 chk("rdata", o_rdata, e);
   endtask
   task automatic outs(input logic w, input logic [2:0] m, input logic [15:0] k);
      repeat (2) @(posedge i_clk);
      #1 chk("outputs", {12'h0, o_ram_wait, o_arb_mode, o_kern_base}, {12'h0, w, m, k});
   endtask
   task automatic fire(input logic [4:0] r, input logic [7:0] n);
      base = ecnt;
      @(posedge i_clk);
      req <= r;
      @(posedge i_clk);
      req <= 5'h00;
      repeat (5) @(posedge i_clk);
      #1 chk("errors", 32'(ecnt - base), 32'(n));
   endtask
   task automatic final_report;
      $display("checks %0d mismatches %0d", check_count, n_fail);
      if (n_fail == 0 && check_count > 0) $display("TEST PASSED");
      else $display("TEST FAILED");
      $finish;
   endtask
   ////////////////////////////////////////
   initial begin
      repeat (6) @(posedge i_clk);
      i_rst <= 1'b0;
      rd(OFS_CFG, CFG_RESET);
      rd(OFS_KPB, 32'h0);
      outs(1'b1, 3'b001, 16'h0);
      $display("test reset done");
      for (int m = 0; m < 3; m++) begin // legal codes only
         wr(OFS_CFG, 32'hFFFF_FFF8 | 32'(m));
         rd(OFS_CFG, 32'h001F_0040 | 32'(m));
         outs(1'b1, 3'(m), 16'h0);
      end
      wr(OFS_CFG | 8'(ALIAS_CLR), 32'h0000_0040);
      outs(1'b0, 3'b010, 16'h0);
      wr(OFS_CFG | 8'(ALIAS_INV), 32'h0000_0043);
      outs(1'b1, 3'b001, 16'h0);
      rd(8'h3C, 32'h0);
      rd(OFS_RAMSZ, RAMSZ_DEFAULT);
      $display("test config done");
      wr(OFS_KPB, 32'hFFFF_73FF); // below ram size
      rd(OFS_KPB, 32'h0000_7000);
      wr(OFS_KPB | 8'(ALIAS_SET), 32'h0000_0C00);
      outs(1'b1, 3'b001, 16'h7C00);
      $display("test kernel base done");
      wr(OFS_IRQ_MASK, 32'h1F);
      fire(5'h1F, 8'd5);
      rd(OFS_IRQ_STAT, 32'h1F);
      chk("irq", 32'(o_irq), 32'h1);
      wr(OFS_IRQ_MASK, 32'h0);
      #1 chk("irq masked", 32'(o_irq), 32'h0);
      wr(OFS_IRQ_MASK, 32'h1F);
      rd(OFS_IRQ_MASK, 32'h1F);
      @(posedge i_clk);
      dbg <= 1'b1;
      fire(5'h1F, 8'd3);
      dbg <= 1'b0;
      for (int n = 0; n < 5; n++) begin
         wr(OFS_CFG | 8'(ALIAS_CLR), 32'h1 << (16 + n));
         fire(5'(1 << n), 8'd0);
      end
      wr(OFS_IRQ_STAT, 32'h1F);
      rd(OFS_IRQ_STAT, 32'h0);
      chk("irq", 32'(o_irq), 32'h0);
      rd(OFS_CFG, 32'h0000_0041);
      $display("test errors done");
      final_report;
   end
   initial begin
      #200000;
      n_fail++;
      final_report;
   end
endmodule
